/* File: common/vct_pkg.sv */
// package: register map, field layouts and timing constants of the calibration timing block
package vct_pkg;

    localparam int unsigned ADDR_W        = 12;
    localparam int unsigned DATA_W        = 32;

    // register byte offsets
    localparam logic [11:0] OFS_INT_VALUE = 12'h000;
    localparam logic [11:0] OFS_REF_CTRL  = 12'h004;
    localparam logic [11:0] OFS_TIMEOUT   = 12'h008;
    localparam logic [11:0] OFS_LOCK_TO   = 12'h00C;
    localparam logic [11:0] OFS_LVL_WAIT  = 12'h010;
    localparam logic [11:0] OFS_BAND_DIV  = 12'h014;
    localparam logic [11:0] OFS_STATUS    = 12'h018;

    // field widths
    localparam int unsigned INT_W         = 16;
    localparam int unsigned TIMEOUT_W     = 10;
    localparam int unsigned LOCK_TO_W     = 5;
    localparam int unsigned LVL_WAIT_W    = 5;
    localparam int unsigned BAND_DIV_W    = 8;

    // reference control field positions
    localparam int unsigned REF_DBL_BIT   = 0;
    localparam int unsigned REF_HALF_BIT  = 1;

    // status field positions
    localparam int unsigned ST_BUSY_BIT   = 0;
    localparam int unsigned ST_DONE_BIT   = 1;
    localparam int unsigned ST_PHASE_LSB  = 2;

    // reset values
    localparam logic [15:0] RST_INT_VALUE = 16'h0000;
    localparam logic [9:0]  RST_TIMEOUT   = 10'h067;
    localparam logic [4:0]  RST_LOCK_TO   = 5'h0C;
    localparam logic [4:0]  RST_LVL_WAIT  = 5'h1E;
    localparam logic [7:0]  RST_BAND_DIV  = 8'h27;

    // sequencer timing
    localparam int unsigned BAND_PRESCALE = 16;
    localparam int unsigned BAND_PERIODS  = 11;
    localparam int unsigned LVL_MULT      = 30;
    localparam int unsigned CNT_W         = 24;

    // minimum settle time and level wait bound, for software guidance
    localparam int unsigned SETTLE_MIN_NS = 20000;
    localparam int unsigned LVL_MIN_NS    = 50000;

    typedef enum logic [4:0] {
        VCT_IDLE   = 5'b00001,
        VCT_SETTLE = 5'b00010,
        VCT_BAND   = 5'b00100,
        VCT_LEVEL  = 5'b01000,
        VCT_DONE   = 5'b10000
    } vct_state_e;

    typedef struct packed {
        logic [TIMEOUT_W-1:0]  timeout;
        logic [LOCK_TO_W-1:0]  lock_to;
        logic [LVL_WAIT_W-1:0] lvl_wait;
        logic [BAND_DIV_W-1:0] band_div;
    } vct_cal_cfg_s;

    typedef struct packed {
        logic       busy;
        logic       done;
        logic [2:0] phase;
    } vct_cal_stat_s;

endpackage

/* File: dv/test_vct_timing.sv */
// testbench: registers, reference path and calibration timing of vct_timing
`timescale 1ns/1ps
module test_vct_timing;
    import vct_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, ref_in, err, bprev;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, cmp_clk, freq_apply, cal_busy, cal_done, band_clk, lvl;
    logic [15:0] int_value;
    int          n_errors = 0, cmp_count = 0, cyc = 0, rises = 0, highs, nb, nl, nr;
    logic [11:0] ra [4] = '{OFS_TIMEOUT, OFS_LOCK_TO, OFS_LVL_WAIT, OFS_BAND_DIV};
    logic [31:0] rv [4] = '{32'h067, 32'h00C, 32'h01E, 32'h027};
    vct_timing dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ref_in(ref_in), .cmp_clk(cmp_clk), .int_value(int_value),
        .freq_apply(freq_apply), .cal_busy(cal_busy), .cal_done(cal_done),
        .band_clk(band_clk), .level_calibration(lvl));
    initial begin
        pclk = 0;
        forever #25 pclk = ~pclk;
    end
    always @(posedge cmp_clk) rises = rises + 1;
    // reference toggles every second clock; cycle ceiling cuts a hang
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc[0]) ref_in <= ~ref_in;
        if (cyc > 70000) begin
            n_errors = n_errors + 1;
            end_sim();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic run(input int to, input int lk, input int lw, input int bd);
        apb(1, OFS_TIMEOUT, to);
        apb(1, OFS_LOCK_TO, lk);
        apb(1, OFS_LVL_WAIT, lw);
        apb(1, OFS_BAND_DIV, bd);
        apb(1, OFS_INT_VALUE, 32'h0044);
        nb = 0;
        nl = 0;
        nr = 0;
        bprev = 0;
        @(posedge pclk);
        chk(freq_apply, 1);
        chk(int_value, 32'h0044);
        while (cal_busy === 1'b1) begin
            nb++;
            nl += lvl;
            nr += (band_clk && !bprev);
            bprev = band_clk;
            @(posedge pclk);
        end
        chk(nb, to*lk + 11*16*bd + 30*lw*to);
        chk(nl, 30*lw*to);
        chk(nr, 11);
        chk(cal_done, 1);
        $display("calibration run done");
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; ref_in = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1;
        for (int i = 0; i < 4; i++) begin
            apb(0, ra[i], 0);
            chk(rd, rv[i]);
        end
        apb(1, OFS_LOCK_TO, 32'hFFFFFFFF); apb(0, OFS_LOCK_TO, 0); chk(rd, 32'h1F);
        apb(1, OFS_LVL_WAIT, 32'hFFFFFFFF); apb(0, OFS_LVL_WAIT, 0); chk(rd, 32'h1F);
        apb(0, 12'h020, 0); chk({rd[30:0], err}, 1);
        $display("register test done");
        for (int k = 0; k < 3; k++) begin
            apb(1, OFS_REF_CTRL, k);
            repeat (8) @(posedge pclk);
            #10 rises = 0;
            highs = 0;
            repeat (40) begin
                #50 highs += cmp_clk;
            end
            chk(rises, k == 0 ? 10 : (k == 1 ? 20 : 5));
            if (k == 2) chk(highs, 20);
        end
        $display("reference test done");
        // settle at least 400 cycles, level wait 2.5 times lock timeout, band clock under 100 kHz
        run(34, 12, 30, 13);
        run(67, 6, 15, 14);
        apb(0, OFS_STATUS, 0); chk(rd, 32'h2);
        end_sim();
    end
endmodule

/* File: dv/vct_timing_monitor.sv */
// checker: register bus answers and calibration sequencing of vct_timing
`timescale 1ns/1ps
module vct_timing_monitor (
    // apb
    input wire logic                       pclk,
    input wire logic                       presetn,
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic                       pwrite,
    input wire logic [vct_pkg::ADDR_W-1:0] paddr,
    input wire logic [vct_pkg::DATA_W-1:0] pwdata,
    input wire logic [vct_pkg::DATA_W-1:0] prdata,
    input wire logic                       pready,
    input wire logic                       pslverr,
    // reference
    input wire logic                       ref_in,
    input wire logic                       cmp_clk,
    // calibration
    input wire logic [vct_pkg::INT_W-1:0]  int_value,
    input wire logic                       freq_apply,
    input wire logic                       cal_busy,
    input wire logic                       cal_done,
    input wire logic                       band_clk,
    input wire logic                       level_calibration
);
    import vct_pkg::*;
    wire acc    = psel && penable;
    wire wr_int = acc && pwrite && paddr == OFS_INT_VALUE;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_apply; wr_int |=> freq_apply; endproperty
    a_apply: assert property (p_apply) else $error("no apply after integer write");
    property p_cause; freq_apply |-> $past(wr_int); endproperty
    a_cause: assert property (p_cause) else $error("apply without integer write");
    property p_start; freq_apply |-> cal_busy; endproperty
    a_start: assert property (p_start) else $error("sequence not started");
    property p_lvl; level_calibration |-> cal_busy && !band_clk; endproperty
    a_lvl: assert property (p_lvl) else $error("level phase overlaps");
    property p_idle; !cal_busy |-> !band_clk && !level_calibration; endproperty
    a_idle: assert property (p_idle) else $error("phase active while idle");
    property p_end; $fell(cal_busy) |-> cal_done; endproperty
    a_end: assert property (p_end) else $error("no completion at end");
    property p_src; $rose(cal_done) |-> $past(level_calibration); endproperty
    a_src: assert property (p_src) else $error("done not after level phase");
    property p_bad; acc && paddr > OFS_STATUS |-> pslverr && (pwrite || prdata == 0); endproperty
    a_bad: assert property (p_bad) else $error("unmapped access not refused");
    property p_ok; acc && paddr <= OFS_STATUS |-> pready && !pslverr; endproperty
    a_ok: assert property (p_ok) else $error("mapped access refused");
endmodule

bind vct_timing vct_timing_monitor mon_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ref_in(ref_in), .cmp_clk(cmp_clk),
    .int_value(int_value), .freq_apply(freq_apply), .cal_busy(cal_busy), .cal_done(cal_done),
    .band_clk(band_clk), .level_calibration(level_calibration));

/* File: hdl/vct_ref_path.sv */
`timescale 1ns/1ps
// reference conditioning: optional doubler and divide-by-2 producing the comparison clock
module vct_ref_path (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // reference
    input  wire logic ref_in,
    // options
    input  wire logic dbl_en,
    input  wire logic half_en,
    // comparison clock
    output logic      cmp_clk
);
    import vct_pkg::*;

    logic ref_s1_q;
    logic ref_s2_q;
    logic ref_s3_q;
    logic base_q;
    logic half_q;
    logic cmp_q;

    // each reference edge gives one pclk-wide pulse; the reference must stay
    // below a quarter of pclk so that neighbouring pulses never merge
    wire ref_edge = ref_s2_q ^ ref_s3_q;
    wire base     = dbl_en ? ref_edge : ref_s2_q;
    wire base_up  = base & ~base_q;
    // one toggle per source period gives an even duty cycle
    wire half_d   = half_q ^ base_up;
    wire cmp_d    = half_en ? half_q : base;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_s1_q <= 1'b0;
            ref_s2_q <= 1'b0;
            ref_s3_q <= 1'b0;
            base_q   <= 1'b0;
            half_q   <= 1'b0;
            cmp_q    <= 1'b0;
        end else begin
            ref_s1_q <= ref_in;
            ref_s2_q <= ref_s1_q;
            ref_s3_q <= ref_s2_q;
            base_q   <= base;
            half_q   <= half_d;
            cmp_q    <= cmp_d;
        end
    end

    assign cmp_clk = cmp_q;

endmodule

/* File: hdl/vct_timing.sv */
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
// calibration timing top: apb registers, reference path and phase sequencer
//
// Function
// - When doubling is selected the reference is multiplied by two before becoming the comparison clock.
// - When halving is selected the reference is divided by two with an even duty cycle.
// - The sequencer holds the settling phase for its programmed length before band selection.
// - Settling lasts timeout times lock timeout comparison cycles; the sequencer counts pclk cycles instead.
// - Band selection runs exactly eleven band clock periods.
// - Level calibration lasts thirty times level wait times timeout comparison cycles; the sequencer counts pclk cycles instead.
// - Level wait and lock timeout are five-bit unsigned fields.
// - A new frequency is applied and calibration started only on a write of the integer register.
module vct_timing (
    // apb
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [vct_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [vct_pkg::DATA_W-1:0]  pwdata,
    output logic      [vct_pkg::DATA_W-1:0]  prdata,
    output logic                             pready,
    output logic                             pslverr,
    // reference pin
    input  wire logic                        ref_in,
    // calibration outputs
    output logic                             cmp_clk,
    output logic      [vct_pkg::INT_W-1:0]   int_value,
    output logic                             freq_apply,
    output logic                             cal_busy,
    output logic                             cal_done,
    output logic                             band_clk,
    output logic                             level_calibration
);
    import vct_pkg::*;

    // registers
    logic [INT_W-1:0]      int_q;
    logic [1:0]            ref_ctrl_q;
    logic [TIMEOUT_W-1:0]  timeout_q;
    logic [LOCK_TO_W-1:0]  lock_to_q;
    logic [LVL_WAIT_W-1:0] lvl_wait_q;
    logic [BAND_DIV_W-1:0] band_div_q;
    logic                  apply_q;
    logic                  done_q;
    logic [DATA_W-1:0]     rd_mux;

    // apb decode
    wire acc       = psel & penable;
    wire wr        = acc & pwrite;
    wire hit_int   = (paddr == OFS_INT_VALUE);
    wire hit_ref   = (paddr == OFS_REF_CTRL);
    wire hit_to    = (paddr == OFS_TIMEOUT);
    wire hit_lock  = (paddr == OFS_LOCK_TO);
    wire hit_lvl   = (paddr == OFS_LVL_WAIT);
    wire hit_band  = (paddr == OFS_BAND_DIV);
    wire hit_stat  = (paddr == OFS_STATUS);
    wire hit_any   = hit_int | hit_ref | hit_to | hit_lock | hit_lvl | hit_band | hit_stat;
    wire wr_int    = wr & hit_int;

    assign pready  = 1'b1;
    assign pslverr = acc & ~hit_any;

    // reference path
    vct_ref_path u_ref (
        .pclk    (pclk),
        .presetn (presetn),
        .ref_in  (ref_in),
        .dbl_en  (ref_ctrl_q[REF_DBL_BIT]),
        .half_en (ref_ctrl_q[REF_HALF_BIT]),
        .cmp_clk (cmp_clk)
    );

    // sequencer state
    vct_state_e        st_q;
    vct_state_e        st_d;
    logic [CNT_W-1:0]  cnt_q;
    logic [CNT_W-1:0]  cnt_d;
    logic [BAND_DIV_W+3:0] bdiv_q;
    logic [BAND_DIV_W+3:0] bdiv_d;
    logic [3:0]        bper_q;
    logic [3:0]        bper_d;

    // reload values; lock timeout and level wait are 5-bit fields
    wire [CNT_W-1:0] settle_len = CNT_W'(timeout_q) * CNT_W'(lock_to_q);
    wire [CNT_W-1:0] level_len  = CNT_W'(LVL_MULT) * CNT_W'(lvl_wait_q)
                                  * CNT_W'(timeout_q);
    wire [BAND_DIV_W+3:0] bdiv_len = (BAND_DIV_W+4)'(BAND_PRESCALE)
                                     * (BAND_DIV_W+4)'(band_div_q);
    wire cnt_last  = (cnt_q <= CNT_W'(1));
    wire bdiv_last = (bdiv_q <= (BAND_DIV_W+4)'(1));
    wire bper_last = (bper_q == 4'(BAND_PERIODS - 1));

    always_comb begin
        st_d   = st_q;
        cnt_d  = cnt_q;
        bdiv_d = bdiv_q;
        bper_d = bper_q;
        case (st_q)
            VCT_IDLE, VCT_DONE: begin
                cnt_d = cnt_q;
            end
            VCT_SETTLE: begin
                cnt_d = cnt_q - CNT_W'(1);
                if (cnt_last) begin
                    st_d   = VCT_BAND;
                    bdiv_d = bdiv_len;
                    bper_d = 4'h0;
                end
            end
            VCT_BAND: begin
                bdiv_d = bdiv_q - (BAND_DIV_W+4)'(1);
                if (bdiv_last) begin
                    bdiv_d = bdiv_len;
                    bper_d = bper_q + 4'h1;
                    if (bper_last) begin
                        st_d  = VCT_LEVEL;
                        cnt_d = level_len;
                    end
                end
            end
            VCT_LEVEL: begin
                cnt_d = cnt_q - CNT_W'(1);
                if (cnt_last) begin
                    st_d = VCT_DONE;
                end
            end
            default: begin
                st_d = VCT_IDLE;
            end
        endcase
        // a write of the integer register restarts the whole sequence
        if (wr_int) begin
            st_d  = VCT_SETTLE;
            cnt_d = settle_len;
        end
    end

    // phases are counted in pclk cycles, pclk standing in as the comparison clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q   <= VCT_IDLE;
            cnt_q  <= '0;
            bdiv_q <= '0;
            bper_q <= 4'h0;
        end else begin
            st_q   <= st_d;
            cnt_q  <= cnt_d;
            bdiv_q <= bdiv_d;
            bper_q <= bper_d;
        end
    end

    // register writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_q      <= RST_INT_VALUE;
            ref_ctrl_q <= 2'h0;
            timeout_q  <= RST_TIMEOUT;
            lock_to_q  <= RST_LOCK_TO;
            lvl_wait_q <= RST_LVL_WAIT;
            band_div_q <= RST_BAND_DIV;
        end else if (wr) begin
            if (hit_int)  int_q      <= pwdata[INT_W-1:0];
            if (hit_ref)  ref_ctrl_q <= pwdata[1:0];
            if (hit_to)   timeout_q  <= pwdata[TIMEOUT_W-1:0];
            if (hit_lock) lock_to_q  <= pwdata[LOCK_TO_W-1:0];
            if (hit_lvl)  lvl_wait_q <= pwdata[LVL_WAIT_W-1:0];
            if (hit_band) band_div_q <= pwdata[BAND_DIV_W-1:0];
        end
    end

    // apply pulse, sticky done, read data
    wire level_end = (st_q == VCT_LEVEL) & cnt_last;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            apply_q  <= 1'b0;
            done_q   <= 1'b0;
        end else begin
            apply_q  <= wr_int;
            done_q   <= level_end | (done_q & ~wr_int);
        end
    end

    vct_cal_stat_s stat;
    assign stat.busy  = (st_q == VCT_SETTLE) | (st_q == VCT_BAND) | (st_q == VCT_LEVEL);
    assign stat.done  = done_q;
    assign stat.phase = {st_q == VCT_LEVEL, st_q == VCT_BAND, st_q == VCT_SETTLE};
    assign rd_mux = hit_int  ? DATA_W'(int_q) :
                    hit_ref  ? DATA_W'(ref_ctrl_q) :
                    hit_to   ? DATA_W'(timeout_q) :
                    hit_lock ? DATA_W'(lock_to_q) :
                    hit_lvl  ? DATA_W'(lvl_wait_q) :
                    hit_band ? DATA_W'(band_div_q) :
                    hit_stat ? DATA_W'({stat.phase, stat.done, stat.busy}) : '0;

    // read data is presented combinationally from the live mux during the access phase
    assign prdata            = rd_mux;
    assign int_value         = int_q;
    assign freq_apply        = apply_q;
    assign cal_busy          = stat.busy;
    assign cal_done          = done_q;
    assign band_clk          = (st_q == VCT_BAND) & (bdiv_q > (BAND_DIV_W+4)'(bdiv_len >> 1));
    assign level_calibration = (st_q == VCT_LEVEL);

endmodule
